/* verif/cmsc_chk.sv */
// Port checker of the clock mode and stop controller.
`timescale 1ns/100ps
module cmsc_chk
#(
	parameter int LAT_CYCLES = 20
)
(
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic       avs_read_in,
	input wire logic       avs_write_in,
	input wire logic       avs_waitrequest_out,
	input wire logic       stop_cmd_in,
	input wire logic       internal_reset_in,
	input wire logic       reset_pin_in,
	input wire logic       reset_pin_out,
	input wire logic       reset_pin_oe_n_out,
	input wire logic       system_reset_n_out,
	input wire logic       bus_clock_en_out,
	input wire logic       loop_enable_out,
	input wire logic       internal_1mhz_reference_en_out,
	input wire logic       crystal_oscillator_en_out,
	input wire logic       rc_clock_en_out,
	input wire logic       autonomous_periodic_irq_en_out,
	input wire logic       low_voltage_interrupt_en_out,
	input wire logic       low_voltage_reset_en_out,
	input wire logic       periodic_tick_count_en_out,
	input wire logic       in_stop_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_stop_clocks_off: assert property (
		in_stop_out |-> !bus_clock_en_out && !loop_enable_out
		&& !internal_1mhz_reference_en_out)
		else $error("clocks run in stop");
	a_rc_kept_on: assert property (
		rc_clock_en_out && autonomous_periodic_irq_en_out)
		else $error("rc clock or periodic irq off");
	a_stop_lv_off: assert property (
		in_stop_out |-> !low_voltage_interrupt_en_out
		&& !low_voltage_reset_en_out)
		else $error("low voltage monitors on in stop");
	a_full_tick_halt: assert property (
		in_stop_out && !crystal_oscillator_en_out
		|-> !periodic_tick_count_en_out)
		else $error("tick counts in full stop");
	a_stop_taken: assert property (
		$rose(stop_cmd_in) && !in_stop_out |-> ##[1:40] in_stop_out)
		else $error("stop not entered");
	a_pin_open_drain: assert property (
		!reset_pin_out) else $error("reset pin driven high");
	a_int_reset_pin: assert property (
		internal_reset_in |=> !reset_pin_oe_n_out)
		else $error("pin not pulled on internal reset");
	a_pin_sys_reset: assert property (
		!reset_pin_in |-> ##[1:3] !system_reset_n_out)
		else $error("pin low did not reset");
	a_write_one_wait: assert property (
		$rose(avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
		else $error("write wait state wrong");
	a_read_one_wait: assert property (
		$rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
		else $error("read wait state wrong");
endmodule // cmsc_chk

bind cmsc_top cmsc_chk #(.LAT_CYCLES(LAT_CYCLES)) chk (.clk_in, .rst_n_in,
	.avs_read_in, .avs_write_in, .avs_waitrequest_out, .stop_cmd_in,
	.internal_reset_in, .reset_pin_in, .reset_pin_out, .reset_pin_oe_n_out,
	.system_reset_n_out, .bus_clock_en_out, .loop_enable_out,
	.internal_1mhz_reference_en_out, .crystal_oscillator_en_out,
	.rc_clock_en_out, .autonomous_periodic_irq_en_out,
	.low_voltage_interrupt_en_out, .low_voltage_reset_en_out,
	.periodic_tick_count_en_out, .in_stop_out);

/* verif/cmsc_cpu_model.sv */
// Behavioural model of the CPU core, debugger, crystal and reset pull.
`timescale 1ns/100ps
module cmsc_cpu_model
(
	input  wire logic clk_in,
	input  wire logic xtal_en_in,
	input  wire logic loop_en_in,
	output logic      stop_cmd_out,
	output logic      wake_out,
	output logic      bdm_out,
	output logic      xtal_up_out,
	output logic      lock_out,
	output logic      pin_n_out
);
	logic [3:0] start_cnt;
	initial
	begin
		{stop_cmd_out, wake_out, bdm_out, xtal_up_out, lock_out} = 5'h00;
		pin_n_out = 1'b1;
		start_cnt = 4'h0;
	end
	// The flag lags the enable so software really has to wait for it.
	always @(posedge clk_in)
	begin
		start_cnt <= !xtal_en_in ? 4'h0 : start_cnt + {3'h0, start_cnt != 4'hF};
		xtal_up_out <= xtal_en_in && start_cnt == 4'hF;
		lock_out <= loop_en_in && xtal_up_out;
	end
	task automatic pulse_stop();
		@(posedge clk_in) stop_cmd_out <= 1'b1;
		@(posedge clk_in) stop_cmd_out <= 1'b0;
	endtask
	task automatic pulse_wake();
		@(posedge clk_in) wake_out <= 1'b1;
		@(posedge clk_in) wake_out <= 1'b0;
	endtask
	task automatic set_bdm(input logic v);
		@(posedge clk_in) bdm_out <= v;
	endtask
	task automatic set_pin(input logic v);
		@(posedge clk_in) pin_n_out <= v;
	endtask
endmodule // cmsc_cpu_model

/* verif/cmsc_tb.sv */
// Self-checking testbench of the clock mode and stop controller.
`timescale 1ns/100ps
module testbench;
	import cmsc_pkg::*;
	localparam int LAT = 2;
	logic        clk_in = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wd = 32'h0, rdata, q;
	logic        wait_cmd = 1'b0, int_rst = 1'b0, waitreq, pin_o, oe_n;
	logic        sys_n, bus_en, loop_en, m1_en, xtal_en, low_voltage_interrupt, low_voltage_reset, wd_en;
	logic        tick_en, in_stop, stop_c, wake, background_debug_mode, xup, lock, ext_n;
	logic        rc_en, api_en, reduced_regulator_mode, wfx, tfx;
	logic [3:0]  be = 4'hF;
	logic [1:0]  src;
	logic [2:0]  rate;
	logic [4:0]  post;
	logic [3:0]  refd;
	int          errors = 0, samples_checked = 0, n, n0, n1;
	wire logic   pin_lvl = ext_n & (oe_n | pin_o);
	always #50 clk_in = ~clk_in;
	cmsc_top #(.LAT_CYCLES(LAT)) uut (.clk_in(clk_in), .rst_n_in(rst_n),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wd), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
		.stop_cmd_in(stop_c), .wake_in(wake), .wait_cmd_in(wait_cmd),
		.background_debug_mode_in(background_debug_mode), .crystal_up_flag_in(xup),
		.loop_lock_in(lock), .internal_reset_in(int_rst),
		.reset_pin_in(pin_lvl), .reset_pin_out(pin_o),
		.reset_pin_oe_n_out(oe_n), .system_reset_n_out(sys_n),
		.bus_source_out(src), .bus_clock_en_out(bus_en),
		.loop_enable_out(loop_en), .internal_1mhz_reference_en_out(m1_en),
		.crystal_oscillator_en_out(xtal_en), .rc_clock_en_out(rc_en),
		.autonomous_periodic_irq_en_out(api_en),
		.low_voltage_interrupt_en_out(low_voltage_interrupt),
		.low_voltage_reset_en_out(low_voltage_reset), .reduced_regulator_mode_out(reduced_regulator_mode),
		.watchdog_count_en_out(wd_en), .watchdog_from_crystal_out(wfx),
		.periodic_tick_count_en_out(tick_en), .tick_from_crystal_out(tfx),
		.watchdog_rate_out(rate), .post_divider_out(post),
		.reference_divider_out(refd), .in_stop_out(in_stop));
	cmsc_cpu_model cpu (.clk_in(clk_in), .xtal_en_in(xtal_en),
		.loop_en_in(loop_en), .stop_cmd_out(stop_c), .wake_out(wake),
		.bdm_out(background_debug_mode), .xtal_up_out(xup), .lock_out(lock), .pin_n_out(ext_n));
	task automatic wrap_up();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic fail_out();
		errors++;
		$display("[FAIL] %0t wait ran out", $time);
		wrap_up();
	endtask
	task automatic ticks(input int k);
		repeat (k) @(posedge clk_in);
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_in);
		{wr, rd, adr, wd} <= {w, !w, a, d};
		k = 0;
		do
		begin
			@(posedge clk_in);
			k++;
		end
		while (waitreq !== 1'b0 && k < 50);
		q = rdata;
		{wr, rd} <= 2'b00;
		if (waitreq !== 1'b0)
			fail_out();
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic wait_stop(input logic v, output int k);
		k = 0;
		while (in_stop !== v && k < 100)
		begin
			@(posedge clk_in);
			k++;
		end
		if (in_stop !== v)
			fail_out();
	endtask
	task automatic stop_run(input logic [31:0] clks, output int k);
		logic ps;
		ps = clks[CMSC_B_PSEUDO_STOP_SELECT] & clks[CMSC_B_XTAL_EN];
		bus(1'b1, CMSC_OFF_CLKS, clks);
		cpu.pulse_stop();
		wait_stop(1'b1, k);
		// The stop flag rises during the latency; the tick source only at the end.
		while (tfx !== ps && k < 100)
		begin
			@(posedge clk_in);
			k++;
		end
		if (tfx !== ps)
			fail_out();
		ticks(1);
	endtask
	task automatic wake_run();
		cpu.pulse_wake();
		wait_stop(1'b0, n);
		ticks(2);
	endtask
	initial
	begin
		ticks(6);
		chk({oe_n, sys_n, src}, 4'h0);
		rst_n <= 1'b1;
		ticks(5);
		chk({sys_n, loop_en, m1_en, bus_en, post, refd}, 13'h1E30);
		chk({rc_en, api_en, reduced_regulator_mode, tfx, wfx}, 5'h18);
		rd_chk(CMSC_OFF_CLKS, 32'h080);
		rd_chk(CMSC_OFF_LOOP, 32'h003);
		bus(1'b1, 4'h2, 32'hFFFF);
		rd_chk(4'h2, 32'h0);
		be <= 4'h1;
		bus(1'b1, CMSC_OFF_CLKS, 32'h1C0);
		be <= 4'hF;
		rd_chk(CMSC_OFF_CLKS, 32'h0C0);
		bus(1'b1, CMSC_OFF_LOOP, 32'h503);
		bus(1'b1, CMSC_OFF_CLKS, 32'h180);
		chk(refd, 4'h5);
		n = 0;
		while (src !== CMSC_SRC_XTAL_REF && n < 100)
		begin
			ticks(1);
			n++;
		end
		chk({src, xtal_en}, {CMSC_SRC_XTAL_REF, 1'b1});
		rd_chk(CMSC_OFF_STATUS, 32'h003);
		bus(1'b1, CMSC_OFF_CLKS, 32'h100);
		ticks(2);
		chk({src, loop_en}, {CMSC_SRC_BYPASS, 1'b1});
		wait_cmd <= 1'b1;
		ticks(3);
		chk({in_stop, bus_en, low_voltage_interrupt, low_voltage_reset, src}, 6'h1F);
		wait_cmd <= 1'b0;
		stop_run(32'h14F, n0);
		chk({xtal_en, wd_en, tick_en}, 3'h7);
		chk({bus_en, loop_en, m1_en, low_voltage_interrupt, low_voltage_reset}, 5'h00);
		chk({rc_en, api_en, reduced_regulator_mode, tfx, wfx}, 5'h1F);
		rd_chk(CMSC_OFF_STATUS, 32'h01D);
		bus(1'b1, CMSC_OFF_CLKS, 32'h000);
		wake_run();
		rd_chk(CMSC_OFF_CLKS, 32'h14F);
		chk(src, CMSC_SRC_BYPASS);
		stop_run(32'h178, n1);
		chk(32'(n1 - n0), LAT);
		chk({wd_en, tick_en}, 2'b01);
		chk({tfx, wfx}, 2'b10);
		wake_run();
		stop_run(32'h003, n);
		chk({xtal_en, wd_en, tick_en}, 3'h0);
		wake_run();
		rd_chk(CMSC_OFF_CLKS, 32'h080);
		chk(src, CMSC_SRC_INT_REF);
		stop_run(32'h010, n);
		chk({wd_en, tick_en}, 2'b10);
		wake_run();
		bus(1'b1, CMSC_OFF_DEBUG, 32'h00A);
		cpu.set_bdm(1'b1);
		ticks(5);
		chk({wd_en, tick_en, rate}, 5'h07);
		cpu.set_bdm(1'b0);
		ticks(5);
		chk({wd_en, tick_en, rate}, 5'h1A);
		bus(1'b1, CMSC_OFF_DEBUG, 32'h002);
		cpu.set_bdm(1'b1);
		ticks(5);
		chk({wd_en, tick_en, rate}, 5'h1A);
		cpu.set_bdm(1'b0);
		int_rst <= 1'b1;
		ticks(2);
		chk(oe_n, 1'b0);
		ticks(2);
		chk(sys_n, 1'b0);
		int_rst <= 1'b0;
		ticks(5);
		chk({oe_n, sys_n}, 2'b11);
		cpu.set_pin(1'b0);
		ticks(5);
		chk(sys_n, 1'b0);
		cpu.set_pin(1'b1);
		ticks(5);
		wrap_up();
	end
endmodule // testbench

/* verilog/cmsc_pkg.sv */
// Package of constants and types for the clock mode and stop controller.
package cmsc_pkg;
	// Register byte offsets on the Avalon-MM slave.
	localparam logic [3:0] CMSC_OFF_CLKS   = 4'h0;
	localparam logic [3:0] CMSC_OFF_LOOP   = 4'h4;
	localparam logic [3:0] CMSC_OFF_DEBUG  = 4'h8;
	localparam logic [3:0] CMSC_OFF_STATUS = 4'hC;
	// Field positions of the clock select register.
	localparam int CMSC_B_BUS_SEL   = 7;
	localparam int CMSC_B_PSEUDO_STOP_SELECT      = 6;
	localparam int CMSC_B_WATCHDOG_STOP_CLOCK_OFF      = 5;
	localparam int CMSC_B_WD_HI     = 4;
	localparam int CMSC_B_TICK_PSE  = 3;
	localparam int CMSC_B_WD_PSE    = 2;
	localparam int CMSC_B_TICK_SEL  = 1;
	localparam int CMSC_B_WD_LO     = 0;
	localparam int CMSC_B_XTAL_EN   = 8;
	// Field positions of the loop configuration register.
	localparam int CMSC_POST_LSB = 0;
	localparam int CMSC_REFD_LSB = 8;
	localparam int CMSC_REFD_W   = 4;
	localparam int CMSC_POST_W   = 5;
	// Field positions of the debug register.
	localparam int CMSC_B_FREEZE = 3;
	localparam int CMSC_RATE_W   = 3;
	// Reset values and the maximum watchdog rate.
	localparam logic [8:0] CMSC_CLKS_RST = 9'h080;
	localparam logic [4:0] CMSC_POST_RST = 5'h03;
	localparam logic [3:0] CMSC_REFD_RST = 4'h0;
	localparam logic [2:0] CMSC_RATE_MAX = 3'h7;
	// Loop oscillator frequency after reset, in MHz.
	localparam int CMSC_LOOP_OSC_MHZ = 50;
	// Stop entry and exit latency of the RC watchdog clock, in ns.
	localparam int CMSC_LAT_NS  = 2000;
	localparam int CMSC_CLK_NS  = 100;
	localparam int CMSC_LAT_CYC = (CMSC_LAT_NS + CMSC_CLK_NS - 1) / CMSC_CLK_NS;
	localparam int CMSC_LAT_W   = 6;
	// Operating modes, Gray coded along run, latency, full stop.
	typedef enum logic [2:0]
	{
		CMSC_RUN        = 3'b000,
		CMSC_ENTER_LAT  = 3'b001,
		CMSC_FULL_STOP  = 3'b011,
		CMSC_PSEUDO     = 3'b111,
		CMSC_EXIT_LAT   = 3'b010
	} cmsc_mode_t;
	// Bus clock source encodings.
	typedef enum logic [1:0]
	{
		CMSC_SRC_INT_REF = 2'b00,
		CMSC_SRC_XTAL_REF = 2'b01,
		CMSC_SRC_BYPASS  = 2'b11
	} cmsc_src_t;
endpackage

/* verilog/cmsc_top.sv */
// Clock mode and stop controller with an Avalon-MM register slave.
// What this block does
// - Reset enters engaged internal reference mode.
// - Reset loop setup 50MHz, post divider 3.
// - Source select zero bypasses; loop stays running.
// - Wait mode changes nothing here.
// - Stop halts bus clocks, loop, 1MHz reference.
// - Stop disables low-voltage interrupt and reset.
// - Pseudo stop needs pseudo bit and crystal.
// - Full stop disables the crystal oscillator.
// - Full stop, watchdog hi zero: counters halt.
// - Full stop wake forces selects to defaults.
// - RC watchdog clock gated by stop-off bit.
// - RC watchdog gating inserts stop latency.
// - Full stop always halts the tick counter.
// - Pseudo stop keeps the crystal running.
// - Pseudo stop, hi zero: enabled counters run.
// - Pseudo stop, hi one: tick on crystal.
// - Pseudo stop leaves clock selects unchanged.
// - Debug freeze holds tick and watchdog counters.
// - Debug freeze may force maximum watchdog rate.
// - Reset pin bidirectional, open-drain on internal reset.
`timescale 1ns/100ps
module cmsc_top
	import cmsc_pkg::*;
#(
	parameter int LAT_CYCLES = CMSC_LAT_CYC
)
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        stop_cmd_in,
	input  wire logic        wake_in,
	input  wire logic        wait_cmd_in,
	input  wire logic        background_debug_mode_in,
	input  wire logic        crystal_up_flag_in,
	input  wire logic        loop_lock_in,
	input  wire logic        internal_reset_in,
	input  wire logic        reset_pin_in,
	output logic             reset_pin_out,
	output logic             reset_pin_oe_n_out,
	output logic             system_reset_n_out,
	output logic [1:0]       bus_source_out,
	output logic             bus_clock_en_out,
	output logic             loop_enable_out,
	output logic             internal_1mhz_reference_en_out,
	output logic             crystal_oscillator_en_out,
	output logic             rc_clock_en_out,
	output logic             autonomous_periodic_irq_en_out,
	output logic             low_voltage_interrupt_en_out,
	output logic             low_voltage_reset_en_out,
	output logic             reduced_regulator_mode_out,
	output logic             watchdog_count_en_out,
	output logic             watchdog_from_crystal_out,
	output logic             periodic_tick_count_en_out,
	output logic             tick_from_crystal_out,
	output logic [2:0]       watchdog_rate_out,
	output logic [4:0]       post_divider_out,
	output logic [3:0]       reference_divider_out,
	output logic             in_stop_out
);
	cmsc_mode_t        mode;
	logic [8:0]        clks;
	logic [4:0]        post_div;
	logic [3:0]        ref_div;
	logic              debug_freeze_bit;
	logic [2:0]        watchdog_rate_field;
	logic [CMSC_LAT_W-1:0] lat_cnt;
	logic              pseudo_latched;
	logic              take_wr;
	logic              sy_up1, sy_up2, sy_lk1, sy_lk2, sy_bd1, sy_bd2;
	logic              sy_rp1, sy_rp2;
	logic              acc;
	logic              in_stop;
	logic              rc_gated;
	logic              pseudo_sel;
	logic              wd_run, tk_run;
	logic [1:0]        next_src;

	// Pins and outside-domain levels pass two flip-flops.
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			{sy_up1, sy_up2, sy_lk1, sy_lk2} <= 4'h0;
			// The pin is pulled low by this block in reset, so start low too.
			{sy_bd1, sy_bd2, sy_rp1, sy_rp2} <= 4'h0;
		end
		else
		begin
			sy_up1 <= crystal_up_flag_in;
			sy_up2 <= sy_up1;
			sy_lk1 <= loop_lock_in;
			sy_lk2 <= sy_lk1;
			sy_bd1 <= background_debug_mode_in;
			sy_bd2 <= sy_bd1;
			sy_rp1 <= reset_pin_in;
			sy_rp2 <= sy_rp1;
		end

	assign acc = avs_read_in | avs_write_in;
	assign take_wr = avs_write_in & ~avs_waitrequest_out;
	assign in_stop = (mode != CMSC_RUN);
	// Either stop chooses its flavour once, at entry.
	assign pseudo_sel = clks[CMSC_B_PSEUDO_STOP_SELECT] & clks[CMSC_B_XTAL_EN];
	assign rc_gated = clks[CMSC_B_WD_HI] & clks[CMSC_B_WATCHDOG_STOP_CLOCK_OFF];

	// Stop sequencing; wait_cmd_in is deliberately ignored.
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			mode <= CMSC_RUN;
			lat_cnt <= '0;
			pseudo_latched <= 1'b0;
		end
		else
		begin
			case (mode)
				CMSC_RUN:
					if (stop_cmd_in)
					begin
						pseudo_latched <= pseudo_sel;
						lat_cnt <= LAT_CYCLES[CMSC_LAT_W-1:0];
						if (rc_gated)
							mode <= CMSC_ENTER_LAT;
						else
							mode <= pseudo_sel ? CMSC_PSEUDO : CMSC_FULL_STOP;
					end
				CMSC_ENTER_LAT:
					if (lat_cnt <= 1)
						mode <= pseudo_latched ? CMSC_PSEUDO : CMSC_FULL_STOP;
					else
						lat_cnt <= lat_cnt - 1'b1;
				CMSC_FULL_STOP, CMSC_PSEUDO:
					if (wake_in)
					begin
						lat_cnt <= LAT_CYCLES[CMSC_LAT_W-1:0];
						mode <= rc_gated ? CMSC_EXIT_LAT : CMSC_RUN;
					end
				CMSC_EXIT_LAT:
					if (lat_cnt <= 1)
						mode <= CMSC_RUN;
					else
						lat_cnt <= lat_cnt - 1'b1;
				default:
					mode <= CMSC_RUN;
			endcase
		end

	// Clock select register; full stop wake forces the bus, watchdog and tick select bits to defaults.
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
			clks <= CMSC_CLKS_RST;
		else if (mode == CMSC_FULL_STOP && wake_in)
		begin
			clks[CMSC_B_BUS_SEL] <= 1'b1;
			clks[CMSC_B_WD_LO] <= 1'b0;
			clks[CMSC_B_TICK_SEL] <= 1'b0;
		end
		else if (!in_stop && take_wr && avs_byteenable_in[0]
			&& avs_address_in == CMSC_OFF_CLKS)
		begin
			clks[7:0] <= avs_writedata_in[7:0];
			if (avs_byteenable_in[1])
				clks[CMSC_B_XTAL_EN] <= avs_writedata_in[CMSC_B_XTAL_EN];
		end

	// Loop configuration and debug registers.
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			post_div <= CMSC_POST_RST;
			ref_div <= CMSC_REFD_RST;
			debug_freeze_bit <= 1'b0;
			watchdog_rate_field <= '0;
		end
		else if (take_wr && !in_stop)
		begin
			if (avs_address_in == CMSC_OFF_LOOP)
			begin
				if (avs_byteenable_in[0])
					post_div <= avs_writedata_in[CMSC_POST_LSB +: CMSC_POST_W];
				if (avs_byteenable_in[1])
					ref_div <= avs_writedata_in[CMSC_REFD_LSB +: CMSC_REFD_W];
			end
			if (avs_address_in == CMSC_OFF_DEBUG && avs_byteenable_in[0])
			begin
				debug_freeze_bit <= avs_writedata_in[CMSC_B_FREEZE];
				watchdog_rate_field <= avs_writedata_in[CMSC_RATE_W-1:0];
			end
		end

	// Every access gets one wait cycle; the price of a registered waitrequest.
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
			avs_waitrequest_out <= 1'b1;
		else
			avs_waitrequest_out <= ~(acc & avs_waitrequest_out);

	// Read data is loaded in the wait cycle and stands until the next read.
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
			avs_readdata_out <= '0;
		else if (avs_read_in && avs_waitrequest_out)
			case (avs_address_in)
				CMSC_OFF_CLKS:   avs_readdata_out <= {23'h0, clks};
				CMSC_OFF_LOOP:   avs_readdata_out <= {20'h0, ref_div,
					3'h0, post_div};
				CMSC_OFF_DEBUG:  avs_readdata_out <= {28'h0,
					debug_freeze_bit, watchdog_rate_field};
				CMSC_OFF_STATUS: avs_readdata_out <= {26'h0, sy_bd2,
					mode, sy_lk2 & ~in_stop, sy_up2};
				default:         avs_readdata_out <= '0;
			endcase

	// Counter gating per mode.
	always_comb
	begin
		wd_run = 1'b1;
		tk_run = 1'b1;
		if (mode == CMSC_FULL_STOP)
		begin
			tk_run = 1'b0;
			wd_run = clks[CMSC_B_WD_HI] & ~clks[CMSC_B_WATCHDOG_STOP_CLOCK_OFF];
		end
		else if (mode == CMSC_PSEUDO)
		begin
			tk_run = clks[CMSC_B_TICK_PSE];
			wd_run = clks[CMSC_B_WD_HI] ? ~clks[CMSC_B_WATCHDOG_STOP_CLOCK_OFF]
				: clks[CMSC_B_WD_PSE];
		end
		else if (mode != CMSC_RUN)
			wd_run = ~rc_gated;
		if (sy_bd2 && debug_freeze_bit)
		begin
			wd_run = 1'b0;
			tk_run = 1'b0;
		end
	end

	// Bus source: loop on internal or crystal reference, or bypass.
	always_comb
	begin
		if (!clks[CMSC_B_BUS_SEL])
			next_src = CMSC_SRC_BYPASS;
		else if (clks[CMSC_B_XTAL_EN] && sy_up2 && sy_lk2)
			next_src = CMSC_SRC_XTAL_REF;
		else
			next_src = CMSC_SRC_INT_REF;
	end

	// Registered outputs.
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			bus_source_out <= CMSC_SRC_INT_REF;
			bus_clock_en_out <= 1'b1;
			loop_enable_out <= 1'b1;
			internal_1mhz_reference_en_out <= 1'b1;
			crystal_oscillator_en_out <= 1'b0;
			rc_clock_en_out <= 1'b1;
			autonomous_periodic_irq_en_out <= 1'b1;
			low_voltage_interrupt_en_out <= 1'b1;
			low_voltage_reset_en_out <= 1'b1;
			reduced_regulator_mode_out <= 1'b0;
			watchdog_count_en_out <= 1'b1;
			watchdog_from_crystal_out <= 1'b0;
			periodic_tick_count_en_out <= 1'b1;
			tick_from_crystal_out <= 1'b0;
			watchdog_rate_out <= '0;
			post_divider_out <= CMSC_POST_RST;
			reference_divider_out <= CMSC_REFD_RST;
			in_stop_out <= 1'b0;
		end
		else
		begin
			bus_source_out <= next_src;
			bus_clock_en_out <= ~in_stop;
			loop_enable_out <= ~in_stop;
			internal_1mhz_reference_en_out <= ~in_stop;
			crystal_oscillator_en_out <= clks[CMSC_B_XTAL_EN]
				& (mode == CMSC_RUN || mode == CMSC_PSEUDO
				|| (in_stop && pseudo_latched));
			rc_clock_en_out <= 1'b1;
			autonomous_periodic_irq_en_out <= 1'b1;
			low_voltage_interrupt_en_out <= ~in_stop;
			low_voltage_reset_en_out <= ~in_stop;
			reduced_regulator_mode_out <= in_stop;
			watchdog_count_en_out <= wd_run;
			watchdog_from_crystal_out <= (mode == CMSC_PSEUDO)
				& ~clks[CMSC_B_WD_HI];
			tick_from_crystal_out <= (mode == CMSC_PSEUDO);
			periodic_tick_count_en_out <= tk_run;
			// Forcing the slowest rate keeps a halted CPU from tripping it.
			watchdog_rate_out <= (sy_bd2 && debug_freeze_bit)
				? CMSC_RATE_MAX : watchdog_rate_field;
			post_divider_out <= post_div;
			reference_divider_out <= ref_div;
			in_stop_out <= in_stop;
		end

	// Reset pin: internal reset pulls it low; an external low resets all.
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			reset_pin_out <= 1'b0;
			reset_pin_oe_n_out <= 1'b0;
			system_reset_n_out <= 1'b0;
		end
		else
		begin
			reset_pin_out <= 1'b0;
			reset_pin_oe_n_out <= ~internal_reset_in;
			system_reset_n_out <= sy_rp2 & ~internal_reset_in;
		end

	// Unused bus inputs are acknowledged without effect.
	logic unused_ok;
	assign unused_ok = acc | wait_cmd_in | (|avs_writedata_in[31:9]);
endmodule // cmsc_top
